// *** shared/ufcl_pkg.sv ***
// constants shared by the uart fifo control and level count block
`default_nettype none
package ufcl_pkg;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned CNT_W      = 5;
	localparam int unsigned ADDR_W     = 8;

	// register byte offsets
	localparam logic [7:0] OFS_FIFO_CONTROL    = 8'h00;
	localparam logic [7:0] OFS_FIFO_FILL_COUNT = 8'h04;
	localparam logic [7:0] OFS_TX_FIFO_DATA    = 8'h08;
	localparam logic [7:0] OFS_RX_FIFO_DATA    = 8'h0c;
	localparam logic [7:0] OFS_SERIAL_STATUS   = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS      = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK        = 8'h18;

	// fifo_control field positions
	localparam int unsigned POS_RX_THR   = 6;
	localparam int unsigned POS_TX_THR   = 4;
	localparam int unsigned POS_MODEM_EN = 3;
	localparam int unsigned POS_TX_FLUSH = 2;
	localparam int unsigned POS_RX_FLUSH = 1;
	localparam int unsigned POS_LOOP     = 0;

	// fifo_fill_count field positions
	localparam int unsigned POS_TX_CNT = 8;
	localparam int unsigned POS_RX_CNT = 0;

	// serial_status and interrupt bit positions
	localparam int unsigned POS_RX_LEVEL   = 0;
	localparam int unsigned POS_TX_LEVEL   = 1;
	localparam int unsigned POS_RX_OVERRUN = 2;
	localparam int unsigned IRQ_W          = 3;

	// reset values
	localparam logic [7:0]       RST_FIFO_CONTROL = 8'h00;
	localparam logic [IRQ_W-1:0] RST_IRQ          = 3'h0;

	// receive and transmit trigger levels per code
	localparam logic [CNT_W-1:0] RX_TRIG_0 = 5'h01;
	localparam logic [CNT_W-1:0] RX_TRIG_1 = 5'h04;
	localparam logic [CNT_W-1:0] RX_TRIG_2 = 5'h08;
	localparam logic [CNT_W-1:0] RX_TRIG_3 = 5'h0e;
	localparam logic [CNT_W-1:0] TX_TRIG_0 = 5'h08;
	localparam logic [CNT_W-1:0] TX_TRIG_1 = 5'h04;
	localparam logic [CNT_W-1:0] TX_TRIG_2 = 5'h02;
	localparam logic [CNT_W-1:0] TX_TRIG_3 = 5'h01;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {RD_IDLE, RD_RESP} ufcl_rd_state_t;
endpackage
`default_nettype wire

// *** hdl/ufcl_sync2.sv ***
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module ufcl_sync2 #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic clock,
	input  wire logic srst,
	input  wire logic d,
	output logic      q
);
	logic meta;
	logic next_meta;
	logic next_q;

	// first stage feeds only the second stage
	always_comb begin
		next_meta = d;
		next_q    = meta;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			meta <= RESET_VAL;
			q    <= RESET_VAL;
		end else begin
			meta <= next_meta;
			q    <= next_q;
		end
	end
endmodule
`default_nettype wire

// *** hdl/ufcl_fifo.sv ***
// byte fifo with fill count and synchronous flush
`timescale 1ns/1ps
`default_nettype none
module ufcl_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic                     clock,
	input  wire logic                     srst,
	input  wire logic                     flush,
	input  wire logic                     push_valid,
	output logic                          push_ready,
	input  wire logic [WIDTH-1:0]         push_data,
	output logic                          pop_valid,
	input  wire logic                     pop_ready,
	output logic [WIDTH-1:0]              pop_data,
	output logic [$clog2(DEPTH):0]        count
);
	localparam int unsigned AW = $clog2(DEPTH);

	// pointers wrap naturally, so depth must be a power of two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("ufcl_fifo: depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             do_push;
	logic             do_pop;

	assign push_ready = (count != (AW + 1)'(DEPTH));
	assign pop_valid  = (count != '0);
	assign pop_data   = mem[rd_ptr];
	assign do_push    = push_valid & push_ready;
	assign do_pop     = pop_valid & pop_ready;

	// flush wins over any push or pop in the same cycle
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (flush) begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count  = '0;
		end else begin
			if (do_push)
				next_wr_ptr = wr_ptr + 1'b1;
			if (do_pop)
				next_rd_ptr = rd_ptr + 1'b1;
			next_count = count + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// storage needs no reset, the count guards stale entries
	always_ff @(posedge clock) begin
		if (do_push && !flush)
			mem[wr_ptr] <= push_data;
	end
endmodule
`default_nettype wire

// *** hdl/ufcl_top.sv ***
// fifo control, level flags, handshake, loopback and fill count of the serial port
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - rx flag when count exceeds 1/4/8/14
// - tx flag when count falls to 8/4/2/1
// - handshake enabled: use cts, drive rts
// - handshake disabled: cts forced active, rts 0
// - tx flush bit empties transmit fifo
// - rx flush bit empties receive fifo
// - reset and standby empty both fifos
// - loopback routes transmit output into receive
// - bits 12:8 report pending transmit bytes
// - bits 4:0 report stored receive bytes
// - count reserved bits read zero
// - fill count read-only, writes ignored
// - both fifos hold sixteen bytes
module ufcl_top (
	input  wire logic                        clock,
	input  wire logic                        srst,
	input  wire logic                        standby,
	input  wire logic [ufcl_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [ufcl_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic                             irq,
	output logic [7:0]                       tx_byte_data,
	output logic                             tx_byte_valid,
	input  wire logic                        tx_byte_ready,
	input  wire logic [7:0]                  rx_byte_data,
	input  wire logic                        rx_byte_valid,
	input  wire logic                        shifter_txd,
	output logic                             shifter_rxd,
	output logic                             serial_tx_pin,
	input  wire logic                        serial_rx_pin,
	input  wire logic                        clear_to_send_in_n,
	output logic                             clear_to_send_n,
	output logic                             request_to_send_out_n,
	output logic                             rx_level_flag,
	output logic                             tx_level_flag
);
	import ufcl_pkg::*;

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------

	function automatic logic [CNT_W-1:0] rx_trigger(input logic [1:0] code);
		case (code)
			2'h0:    rx_trigger = RX_TRIG_0;
			2'h1:    rx_trigger = RX_TRIG_1;
			2'h2:    rx_trigger = RX_TRIG_2;
			default: rx_trigger = RX_TRIG_3;
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] tx_trigger(input logic [1:0] code);
		case (code)
			2'h0:    tx_trigger = TX_TRIG_0;
			2'h1:    tx_trigger = TX_TRIG_1;
			2'h2:    tx_trigger = TX_TRIG_2;
			default: tx_trigger = TX_TRIG_3;
		endcase
	endfunction

	// word-aligned decode; low address bits are ignored
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		hit = ({a[ADDR_W-1:2], 2'h0} == ofs);
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = hit(a, OFS_FIFO_CONTROL) | hit(a, OFS_FIFO_FILL_COUNT) | hit(a, OFS_TX_FIFO_DATA)
			| hit(a, OFS_RX_FIFO_DATA) | hit(a, OFS_SERIAL_STATUS) | hit(a, OFS_IRQ_STATUS)
			| hit(a, OFS_IRQ_MASK);
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------

	logic [7:0]        fifo_control, next_fifo_control;
	logic [IRQ_W-1:0]  irq_status, next_irq_status, irq_mask, next_irq_mask, irq_events;
	logic              aw_held, w_held, w_lane0, next_aw_held, next_w_held, next_w_lane0, next_bvalid;
	logic [ADDR_W-1:0] aw_addr, next_aw_addr;
	logic [31:0]       w_data, next_w_data, next_rdata;
	logic [1:0]        next_bresp, next_rresp;
	ufcl_rd_state_t    rd_state, next_rd_state;
	logic              do_write, do_read, tx_push, rx_pop, rx_push_ready;
	logic              rx_pop_valid, tx_pop_valid, tx_flush, rx_flush, next_rx_level, next_tx_level;
	logic [7:0]        rx_pop_data;
	logic [CNT_W-1:0]  tx_count, rx_count;
	logic              cts_pin_sync, rx_pin_sync, next_clear_to_send_n, next_rts_n;
	logic              next_shifter_rxd, next_serial_tx;
	logic [15:0]       fill_count;

	// ----------------------------------------------------------------
	// fifos and pin synchronisers
	// ----------------------------------------------------------------

	// hardware reset and standby empty both fifos; a held flush bit empties only its own fifo
	assign tx_flush = standby | fifo_control[POS_TX_FLUSH];
	assign rx_flush = standby | fifo_control[POS_RX_FLUSH];

	ufcl_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clock      (clock),
		.srst       (srst),
		.flush      (tx_flush),
		.push_valid (tx_push),
		.push_ready (),
		.push_data  (w_data[7:0]),
		.pop_valid  (tx_pop_valid),
		.pop_ready  (tx_byte_ready & ~clear_to_send_n),
		.pop_data   (tx_byte_data),
		.count      (tx_count)
	);

	ufcl_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clock      (clock),
		.srst       (srst),
		.flush      (rx_flush),
		.push_valid (rx_byte_valid),
		.push_ready (rx_push_ready),
		.push_data  (rx_byte_data),
		.pop_valid  (rx_pop_valid),
		.pop_ready  (rx_pop),
		.pop_data   (rx_pop_data),
		.count      (rx_count)
	);

	ufcl_sync2 #(.RESET_VAL (1'b1)) u_cts_sync (
		.clock (clock),
		.srst  (srst),
		.d     (clear_to_send_in_n),
		.q     (cts_pin_sync)
	);

	ufcl_sync2 #(.RESET_VAL (1'b1)) u_rx_sync (
		.clock (clock),
		.srst  (srst),
		.d     (serial_rx_pin),
		.q     (rx_pin_sync)
	);

	// transmitter only sees a byte while clear-to-send is active
	assign tx_byte_valid = tx_pop_valid & ~clear_to_send_n;

	// ----------------------------------------------------------------
	// line side: handshake and loopback
	// ----------------------------------------------------------------

	// outputs pass a flop so the pins never glitch on a control write
	always_comb begin
		if (fifo_control[POS_MODEM_EN]) begin
			next_clear_to_send_n = cts_pin_sync;
			next_rts_n           = next_rx_level;
		end else begin
			next_clear_to_send_n = 1'b0;
			next_rts_n           = 1'b0;
		end
		if (fifo_control[POS_LOOP]) begin
			next_shifter_rxd = shifter_txd;
			next_serial_tx   = 1'b1;        // line idles at mark during self-test
		end else begin
			next_shifter_rxd = rx_pin_sync;
			next_serial_tx   = shifter_txd;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			clear_to_send_n       <= 1'b0;
			request_to_send_out_n <= 1'b0;
			shifter_rxd           <= 1'b1;
			serial_tx_pin         <= 1'b1;
		end else begin
			clear_to_send_n       <= next_clear_to_send_n;
			request_to_send_out_n <= next_rts_n;
			shifter_rxd           <= next_shifter_rxd;
			serial_tx_pin         <= next_serial_tx;
		end
	end

	// ----------------------------------------------------------------
	// level flags and interrupts
	// ----------------------------------------------------------------

	// events are rising edges of the flags plus receive overrun
	always_comb begin
		next_rx_level = (rx_count > rx_trigger(fifo_control[POS_RX_THR+:2]));
		next_tx_level = (tx_count <= tx_trigger(fifo_control[POS_TX_THR+:2]));
		irq_events                 = '0;
		irq_events[POS_RX_LEVEL]   = next_rx_level & ~rx_level_flag;
		irq_events[POS_TX_LEVEL]   = next_tx_level & ~tx_level_flag;
		irq_events[POS_RX_OVERRUN] = rx_byte_valid & ~rx_push_ready;
		next_irq_mask              = irq_mask;
		next_irq_status            = irq_status;
		if (do_write && w_lane0 && hit(aw_addr, OFS_IRQ_MASK))
			next_irq_mask = w_data[IRQ_W-1:0];
		if (do_write && w_lane0 && hit(aw_addr, OFS_IRQ_STATUS))
			next_irq_status = irq_status & ~w_data[IRQ_W-1:0];
		// a new event wins over a clear in the same cycle
		next_irq_status = next_irq_status | irq_events;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rx_level_flag <= 1'b0;
			tx_level_flag <= 1'b1;
			irq_status    <= RST_IRQ;
			irq_mask      <= RST_IRQ;
		end else begin
			rx_level_flag <= next_rx_level;
			tx_level_flag <= next_tx_level;
			irq_status    <= next_irq_status;
			irq_mask      <= next_irq_mask;
		end
	end

	assign irq = |(irq_status & irq_mask);

	// ----------------------------------------------------------------
	// bus write channel
	// ----------------------------------------------------------------

	assign s_axi_awready = ~aw_held;
	assign s_axi_wready  = ~w_held;
	assign do_write      = aw_held & w_held & ~s_axi_bvalid;
	assign tx_push       = do_write & w_lane0 & hit(aw_addr, OFS_TX_FIFO_DATA);

	// address and data are latched in either order, then written once
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_lane0 = w_lane0;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		next_fifo_control = fifo_control;
		if (s_axi_awvalid && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held) begin
			next_w_held  = 1'b1;
			next_w_data  = s_axi_wdata;
			next_w_lane0 = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			// fill count and serial status addresses take no write
			if (w_lane0 && hit(aw_addr, OFS_FIFO_CONTROL))
				next_fifo_control = w_data[7:0];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= '0;
			w_data       <= '0;
			w_lane0      <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			fifo_control <= RST_FIFO_CONTROL;
		end else begin
			aw_held      <= next_aw_held;
			w_held       <= next_w_held;
			aw_addr      <= next_aw_addr;
			w_data       <= next_w_data;
			w_lane0      <= next_w_lane0;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp  <= next_bresp;
			fifo_control <= next_fifo_control;
		end
	end

	// ----------------------------------------------------------------
	// bus read channel
	// ----------------------------------------------------------------

	// reserved count bits are tied low
	assign fill_count = {3'h0, tx_count, 3'h0, rx_count};

	assign s_axi_arready = (rd_state == RD_IDLE);
	assign s_axi_rvalid  = (rd_state == RD_RESP);
	assign do_read       = s_axi_arvalid & s_axi_arready;
	// reading the receive data pops one byte; an empty fifo reads zero
	assign rx_pop        = do_read & hit(s_axi_araddr, OFS_RX_FIFO_DATA) & rx_pop_valid;

	always_comb begin
		next_rd_state = rd_state;
		next_rdata    = s_axi_rdata;
		next_rresp    = s_axi_rresp;
		case (rd_state)
			RD_IDLE: begin
				if (do_read) begin
					next_rd_state = RD_RESP;
					next_rresp    = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
					next_rdata    = '0;
					if (hit(s_axi_araddr, OFS_FIFO_CONTROL))
						next_rdata = {24'h0, fifo_control};
					if (hit(s_axi_araddr, OFS_FIFO_FILL_COUNT))
						next_rdata = {16'h0, fill_count};
					if (hit(s_axi_araddr, OFS_RX_FIFO_DATA) && rx_pop_valid)
						next_rdata = {24'h0, rx_pop_data};
					if (hit(s_axi_araddr, OFS_SERIAL_STATUS))
						next_rdata = {30'h0, tx_level_flag, rx_level_flag};
					if (hit(s_axi_araddr, OFS_IRQ_STATUS))
						next_rdata = {29'h0, irq_status};
					if (hit(s_axi_araddr, OFS_IRQ_MASK))
						next_rdata = {29'h0, irq_mask};
				end
			end
			RD_RESP: begin
				if (s_axi_rready)
					next_rd_state = RD_IDLE;
			end
			default: next_rd_state = RD_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rd_state    <= RD_IDLE;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			rd_state    <= next_rd_state;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end
endmodule
`default_nettype wire

// *** verif/ufcl_monitor.sv ***
// port checker for the fifo control and level count block
`timescale 1ns/1ps
`default_nettype none
module ufcl_monitor
	import ufcl_pkg::*;
(
	input  wire logic                        clock,
	input  wire logic                        srst,
	input  wire logic                        standby,
	input  wire logic [ufcl_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	input  wire logic                        s_axi_arready,
	input  wire logic [31:0]                 s_axi_rdata,
	input  wire logic [1:0]                  s_axi_rresp,
	input  wire logic                        s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic [1:0]                  s_axi_bresp,
	input  wire logic                        s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic                        tx_byte_valid,
	input  wire logic                        shifter_txd,
	input  wire logic                        serial_tx_pin,
	input  wire logic                        clear_to_send_n,
	input  wire logic                        clear_to_send_in_n,
	input  wire logic                        request_to_send_out_n,
	input  wire logic                        rx_level_flag,
	input  wire logic                        tx_level_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	logic [7:0] rd_addr;
	logic [7:0] next_rd_addr;
	logic       fill_rd;
	// ----
	// address of the read in flight, so read data can be judged by register
	// ----
	always_comb begin
		next_rd_addr = rd_addr;
		if (s_axi_arvalid && s_axi_arready) next_rd_addr = s_axi_araddr;
	end
	always_ff @(posedge clock) begin
		rd_addr <= next_rd_addr;
	end
	assign fill_rd = s_axi_rvalid && rd_addr[7:2] == OFS_FIFO_FILL_COUNT[7:2];
	property p_fill_rsvd;
		fill_rd |-> s_axi_rdata[31:13] == 19'h0 && s_axi_rdata[7:5] == 3'h0;
	endproperty
	a_fill_rsvd: assert property (p_fill_rsvd) else $error("reserved count bits set");
	property p_fill_max;
		fill_rd |-> s_axi_rdata[12:8] <= 5'h10 && s_axi_rdata[4:0] <= 5'h10;
	endproperty
	a_fill_max: assert property (p_fill_max) else $error("fill count beyond depth");
	property p_unmapped;
		s_axi_rvalid && rd_addr >= 8'h1c |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	property p_cts_gate;
		clear_to_send_n |-> !tx_byte_valid && $past(clear_to_send_in_n, 3);
	endproperty
	a_cts_gate: assert property (p_cts_gate) else $error("cts inactive without pin or byte offered");
	property p_rts_flag;
		request_to_send_out_n |-> rx_level_flag;
	endproperty
	a_rts_flag: assert property (p_rts_flag) else $error("rts raised without rx level");
	property p_standby;
		standby ##1 standby |=> !rx_level_flag && tx_level_flag && !tx_byte_valid;
	endproperty
	a_standby: assert property (p_standby) else $error("fifos not empty in standby");
	property p_tx_pin;
		!serial_tx_pin |-> !$past(shifter_txd);
	endproperty
	a_tx_pin: assert property (p_tx_pin) else $error("tx pin low without shifter low");
	property p_bhold;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response not retired");
	property p_rhold;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_rhold: assert property (p_rhold) else $error("read response not retired");
	c_full: cover property (fill_rd && s_axi_rdata[12:8] == 5'h10);
	c_stby: cover property (standby ##1 standby);
	c_rts: cover property (request_to_send_out_n);
endmodule
`default_nettype wire

// *** verif/ufcl_line_model.sv ***
// far side of the byte shifters: takes and offers bytes on command
`timescale 1ns/1ps
`default_nettype none
module ufcl_line_model (
	input  wire logic       clock,
	output logic            tx_byte_ready,
	output logic [7:0]      rx_byte_data,
	output logic            rx_byte_valid,
	input  wire logic       request_to_send_out_n
);
	initial begin
		tx_byte_ready = 1'b0;
		rx_byte_valid = 1'b0;
		rx_byte_data = 8'h00;
	end
	// ready for one edge only; stalling is the default so fill levels hold
	task automatic take1();
		tx_byte_ready <= 1'b1;
		@(posedge clock);
		tx_byte_ready <= 1'b0;
	endtask
	// one byte pulse; idle data shows the inverse so stale bytes never pass
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 20 && request_to_send_out_n; i++) @(posedge clock);
		@(posedge clock);
		rx_byte_valid <= 1'b1;
		rx_byte_data <= b;
		@(posedge clock);
		rx_byte_valid <= 1'b0;
		rx_byte_data <= ~b;
	endtask
endmodule
`default_nettype wire

// *** verif/ufcl_top_tb.sv ***
// self-checking bench for the fifo control and level count block
`timescale 1ns/1ps
`default_nettype none
module ufcl_top_tb;
	import ufcl_pkg::*;
	logic        clock = 0, srst = 1, standby = 0, shifter_txd = 1, serial_rx_pin = 1, clear_to_send_in_n = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, tx_byte_data, rx_byte_data;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        tx_byte_valid, tx_byte_ready, rx_byte_valid, shifter_rxd, serial_tx_pin, clear_to_send_n;
	logic        request_to_send_out_n, rx_level_flag, tx_level_flag;
	int          errors = 0, checks = 0;
	int          ttrg[4] = '{8, 4, 2, 1};
	int          rtrg[4] = '{1, 4, 8, 14};
	always #5 clock = ~clock;
	ufcl_top dut (.*);
	ufcl_line_model line (.clock, .tx_byte_ready, .rx_byte_data, .rx_byte_valid, .request_to_send_out_n);
	// ----
	// checking and bus tasks
	// ----
	task automatic test_done();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", nm, e, g);
			errors++;
		end
	endtask
	task automatic hang(input logic ok);
		if (!ok) begin
			errors++;
			test_done();
		end
	endtask
	// called just after an edge; every answer is taken at the edge where it is seen
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rsp = s_axi_bresp;
		hang(n < 50);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rsp = s_axi_rresp;
		hang(n < 50);
		chk($sformatf("reg %h", a), e, s_axi_rdata);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		rc(OFS_FIFO_CONTROL, 32'h0);
		rc(OFS_FIFO_FILL_COUNT, 32'h0);
		rc(OFS_SERIAL_STATUS, 32'h2);
		rc(8'h1c, 32'h0);
		chk("rresp", 32'(RESP_SLVERR), 32'(rsp));
		wr(8'h1c, 32'h1);
		chk("bresp", 32'(RESP_SLVERR), 32'(rsp));
		$display("test reset done");
		// seventeen pushes, the last one must be dropped at full depth
		for (int i = 0; i < 17; i++) wr(OFS_TX_FIFO_DATA, 32'(i));
		rc(OFS_FIFO_FILL_COUNT, 32'h1000);
		wr(OFS_FIFO_FILL_COUNT, 32'hffff);
		rc(OFS_FIFO_FILL_COUNT, 32'h1000);
		for (int c = 16; c >= 0; c--) begin
			for (int k = 0; k < 4; k++) begin
				wr(OFS_FIFO_CONTROL, 32'(k << 4));
				settle(2);
				chk("tx_level_flag", 32'(c <= ttrg[k]), 32'(tx_level_flag));
			end
			rc(OFS_FIFO_FILL_COUNT, 32'(c << 8));
			if (c > 0) chk("tx_byte_data", 32'(16 - c), 32'(tx_byte_data));
			if (c > 0) line.take1();
		end
		$display("test tx level done");
		wr(OFS_TX_FIFO_DATA, 32'h5a);
		wr(OFS_FIFO_CONTROL, 32'h04);
		rc(OFS_FIFO_CONTROL, 32'h04);
		rc(OFS_FIFO_FILL_COUNT, 32'h0);
		wr(OFS_TX_FIFO_DATA, 32'h11);
		rc(OFS_FIFO_FILL_COUNT, 32'h0);
		wr(OFS_FIFO_CONTROL, 32'h0);
		wr(OFS_TX_FIFO_DATA, 32'h33);
		rc(OFS_FIFO_FILL_COUNT, 32'h100);
		chk("tx_byte_data", 32'h33, 32'(tx_byte_data));
		s_axi_wstrb <= 4'he;
		wr(OFS_FIFO_CONTROL, 32'hff);
		s_axi_wstrb <= 4'hf;
		rc(OFS_FIFO_CONTROL, 32'h0);
		$display("test tx flush done");
		wr(OFS_IRQ_STATUS, 32'h7);
		for (int n = 1; n <= 16; n++) begin
			line.send(8'(n));
			for (int k = 0; k < 4; k++) begin
				wr(OFS_FIFO_CONTROL, 32'(k << 6));
				settle(2);
				chk("rx_level_flag", 32'(n > rtrg[k]), 32'(rx_level_flag));
			end
			rc(OFS_FIFO_FILL_COUNT, 32'h100 | n);
		end
		line.send(8'hee);
		rc(OFS_FIFO_FILL_COUNT, 32'h110);
		rc(OFS_IRQ_STATUS, 32'h5);
		wr(OFS_IRQ_MASK, 32'h4);
		settle(1);
		chk("irq", 32'h1, 32'(irq));
		wr(OFS_IRQ_STATUS, 32'h7);
		rc(OFS_IRQ_STATUS, 32'h0);
		settle(1);
		chk("irq", 32'h0, 32'(irq));
		wr(OFS_IRQ_MASK, 32'h0);
		rc(OFS_RX_FIFO_DATA, 32'h1);
		rc(OFS_FIFO_FILL_COUNT, 32'h10f);
		wr(OFS_FIFO_CONTROL, 32'h02);
		rc(OFS_FIFO_FILL_COUNT, 32'h100);
		wr(OFS_FIFO_CONTROL, 32'h0);
		$display("test rx level done");
		@(posedge clock) clear_to_send_in_n <= 1'b1;
		settle(4);
		chk("cts", 32'h0, {clear_to_send_n, tx_byte_valid, request_to_send_out_n} ^ 3'h2);
		wr(OFS_FIFO_CONTROL, 32'h08);
		settle(4);
		chk("cts", 32'h4, {clear_to_send_n, tx_byte_valid, request_to_send_out_n});
		line.send(8'h01);
		line.send(8'h02);
		settle(2);
		chk("rts", 32'h1, 32'(request_to_send_out_n));
		@(posedge clock) clear_to_send_in_n <= 1'b0;
		settle(4);
		chk("cts", 32'h1, {clear_to_send_n, tx_byte_valid});
		$display("test modem done");
		wr(OFS_FIFO_CONTROL, 32'h01);
		for (int b = 0; b < 2; b++) begin
			@(posedge clock) shifter_txd <= 1'(1 - b);
			settle(2);
			chk("loop", {30'h0, 1'(1 - b), 1'b1}, {30'h0, shifter_rxd, serial_tx_pin});
		end
		wr(OFS_FIFO_CONTROL, 32'h0);
		@(posedge clock) serial_rx_pin <= 1'b0;
		settle(4);
		chk("pins", 32'h0, {shifter_rxd, serial_tx_pin});
		$display("test loop done");
		@(posedge clock) standby <= 1'b1;
		settle(3);
		@(posedge clock) standby <= 1'b0;
		rc(OFS_FIFO_FILL_COUNT, 32'h0);
		wr(OFS_TX_FIFO_DATA, 32'h77);
		srst <= 1'b1;
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		rc(OFS_FIFO_FILL_COUNT, 32'h0);
		$display("test standby done");
		test_done();
	end
endmodule
bind ufcl_top ufcl_monitor mon (.*);
`default_nettype wire
